// [pss_cfg.svh]
`ifndef PSS_CFG_SVH
`define PSS_CFG_SVH

// upper three bits of the pin-programmed primary address
`define PSS_PRIMARY_TOP 3'b010
`define PSS_BROADCAST_ADDR 7'h30
`define PSS_ALERT_ADDR 7'h0c
`define PSS_PTR_WIDTH 5
`define PSS_PTR_RESET 5'h00
`define PSS_DATA_WIDTH 8
`define PSS_FIFO_DEPTH 4
// position of the read/write bit inside the address byte
`define PSS_RW_BIT 0

`endif

// [pss_pkg.sv]
`include "pss_cfg.svh"
`default_nettype none

package pss_pkg;

    typedef enum logic [3:0] {
        PSS_IDLE      = 4'h0,
        PSS_ADDR      = 4'h1,
        PSS_ADDR_ACK  = 4'h3,
        PSS_CMD       = 4'h2,
        PSS_CMD_ACK   = 4'h6,
        PSS_WDATA     = 4'h7,
        PSS_WDATA_ACK = 4'h5,
        PSS_RDATA     = 4'h4,
        PSS_RD_ACK    = 4'hc,
        PSS_IGNORE    = 4'hd
    } pss_state_e;

    typedef logic [`PSS_PTR_WIDTH-1:0] pss_ptr_t;
    typedef logic [`PSS_DATA_WIDTH-1:0] pss_byte_t;

endpackage : pss_pkg

`default_nettype wire

// [pss_fifo_if.sv]
`default_nettype none

interface pss_fifo_if #(
    parameter int WIDTH = 13
);
    logic push_valid;
    logic push_ready;
    logic [WIDTH-1:0] push_data;
    logic pop_valid;
    logic pop_ready;
    logic [WIDTH-1:0] pop_data;

    modport buffer (
        input push_valid,
        output push_ready,
        input push_data,
        output pop_valid,
        input pop_ready,
        output pop_data
    );

    modport user (
        output push_valid,
        input push_ready,
        output push_data,
        input pop_valid,
        output pop_ready,
        input pop_data
    );
endinterface : pss_fifo_if

`default_nettype wire

// [pss_fifo.sv]
`default_nettype none

// dual-clock fifo; depth must be a power of two and at least 4
module pss_fifo #(
    parameter int WIDTH = 13,
    parameter int DEPTH = 4
) (
    input wire logic wclk,
    input wire logic wrst_n,
    input wire logic rclk,
    input wire logic rrst_n,
    pss_fifo_if.buffer port
);
    localparam int AW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW:0] wbin;
    logic [AW:0] wgray;
    logic [AW:0] rbin;
    logic [AW:0] rgray;
    logic [AW:0] rg_s1;
    logic [AW:0] rg_s2;
    logic [AW:0] wg_s1;
    logic [AW:0] wg_s2;
    logic full;
    logic empty;
    logic do_push;
    logic do_pop;
    logic [AW:0] next_wbin;
    logic [AW:0] next_rbin;

    function automatic logic [AW:0] to_gray(input logic [AW:0] b);
        return b ^ (b >> 1);
    endfunction : to_gray

    assign full = (wgray == {~rg_s2[AW:AW-1], rg_s2[AW-2:0]});
    assign empty = (rgray == wg_s2);
    assign do_push = port.push_valid && !full;
    assign do_pop = port.pop_ready && !empty;
    assign next_wbin = wbin + {{AW{1'b0}}, 1'b1};
    assign next_rbin = rbin + {{AW{1'b0}}, 1'b1};
    assign port.push_ready = !full;
    assign port.pop_valid = !empty;
    assign port.pop_data = mem[rbin[AW-1:0]];

    always_ff @(posedge wclk)
    begin
        if (do_push)
        begin
            mem[wbin[AW-1:0]] <= port.push_data;
        end
    end

    // each side also syncs the other's gray pointer for full or empty
    always_ff @(posedge wclk or negedge wrst_n)
    begin
        if (!wrst_n)
        begin
            wbin <= '0;
            wgray <= '0;
            rg_s1 <= '0;
            rg_s2 <= '0;
        end
        else
        begin
            rg_s1 <= rgray;
            rg_s2 <= rg_s1;
            if (do_push)
            begin
                wbin <= next_wbin;
                wgray <= to_gray(next_wbin);
            end
        end
    end

    always_ff @(posedge rclk or negedge rrst_n)
    begin
        if (!rrst_n)
        begin
            rbin <= '0;
            rgray <= '0;
            wg_s1 <= '0;
            wg_s2 <= '0;
        end
        else
        begin
            wg_s1 <= wgray;
            wg_s2 <= wg_s1;
            if (do_pop)
            begin
                rbin <= next_rbin;
                rgray <= to_gray(next_rbin);
            end
        end
    end
endmodule : pss_fifo

`default_nettype wire

// [pss_slave.sv]
`include "pss_cfg.svh"
`default_nettype none

// How it works
// - interrupt pin changes only between transactions
// - start after power-up holds interrupt until stop
// - data sampled on input pin, driven open-drain
// - primary address is 010 plus select pins
// - broadcast address 0110000 accepted for writes
// - alert address acknowledged only while interrupting
// - slave only; write, read, receive byte
// - data falling with clock high starts transaction
// - data rising with clock high ends transaction
// - internal reset raises an interrupt
// - pointer keeps low five bits, stop clears
// - receive byte returns register zero
// - lost alert arbitration aborts; success releases interrupt
module pss_slave
    import pss_pkg::*;
#(
    parameter int FIFO_DEPTH = `PSS_FIFO_DEPTH
) (
    input wire logic clock,
    input wire logic nrst,
    input wire logic link_clock,
    input wire logic scl_in,
    input wire logic serial_data_input,
    output logic serial_data_output,
    output logic serial_data_output_oe,
    input wire logic [3:0] address_select_pins,
    output logic irq_n,
    input wire logic event_pending,
    input wire logic int_release,
    output pss_ptr_t rd_index,
    output logic rd_strobe,
    input wire pss_byte_t rd_data,
    output logic wr_valid,
    output pss_ptr_t wr_index,
    output pss_byte_t wr_data,
    input wire logic wr_ready
);
    localparam int QW = `PSS_PTR_WIDTH + `PSS_DATA_WIDTH;

    logic srst_q1, srst_n, lrst_q1, lrst_n;

    logic scl_q1, scl_s, scl_d;
    logic sda_q1, sda_s, sda_d;
    logic [3:0] pins_q1, pins_s;
    logic int_q1, int_s;
    logic start_seen, stop_seen, scl_rise, scl_fall;

    pss_state_e state;
    logic [2:0] bit_cnt;
    pss_byte_t shift, tx, rx_byte;
    pss_ptr_t ptr;
    logic is_read, is_alert, ack_on, sda_oe, busy;
    logic push_valid;
    logic [QW-1:0] push_data;
    logic alert_tgl, rd_req_tgl;
    logic rd_ack_q1, rd_ack_s, rd_ack_d;
    pss_byte_t rd_hold_link;

    logic busy_q1, busy_s;
    logic alert_q1, alert_s, alert_d;
    logic req_q1, req_s, req_d;
    logic rd_ack_tgl;
    pss_byte_t rd_hold;
    logic reset_pending, armed;

    pss_fifo_if #(.WIDTH(QW)) wq ();

    function automatic logic primary_match(input logic [6:0] a, input logic [3:0] pins);
        return a == {`PSS_PRIMARY_TOP, pins};
    endfunction : primary_match

    assign rx_byte = {shift[6:0], sda_s};
    assign start_seen = scl_s && scl_d && sda_d && !sda_s;
    assign stop_seen = scl_s && scl_d && !sda_d && sda_s;
    assign scl_rise = scl_s && !scl_d;
    assign scl_fall = !scl_s && scl_d;
    assign wq.push_valid = push_valid;
    assign wq.push_data = push_data;
    assign wq.pop_ready = !wr_valid || wr_ready;

    pss_fifo #(.WIDTH(QW), .DEPTH(FIFO_DEPTH)) u_fifo (
        .wclk(link_clock),
        .wrst_n(lrst_n),
        .rclk(clock),
        .rrst_n(srst_n),
        .port(wq.buffer)
    );

    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            srst_q1 <= 1'b0;
            srst_n <= 1'b0;
        end
        else
        begin
            srst_q1 <= 1'b1;
            srst_n <= srst_q1;
        end
    end

    always_ff @(posedge link_clock or negedge nrst)
    begin
        if (!nrst)
        begin
            lrst_q1 <= 1'b0;
            lrst_n <= 1'b0;
        end
        else
        begin
            lrst_q1 <= 1'b1;
            lrst_n <= lrst_q1;
        end
    end

    // pins and interrupt level enter through two flops
    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            scl_q1 <= 1'b1;
            scl_s <= 1'b1;
            scl_d <= 1'b1;
            sda_q1 <= 1'b1;
            sda_s <= 1'b1;
            sda_d <= 1'b1;
            pins_q1 <= 4'h0;
            pins_s <= 4'h0;
            int_q1 <= 1'b0;
            int_s <= 1'b0;
            rd_ack_q1 <= 1'b0;
            rd_ack_s <= 1'b0;
            rd_ack_d <= 1'b0;
        end
        else
        begin
            scl_q1 <= scl_in;
            scl_s <= scl_q1;
            scl_d <= scl_s;
            sda_q1 <= serial_data_input;
            sda_s <= sda_q1;
            sda_d <= sda_s;
            pins_q1 <= address_select_pins;
            pins_s <= pins_q1;
            int_q1 <= !irq_n;
            int_s <= int_q1;
            rd_ack_q1 <= rd_ack_tgl;
            rd_ack_s <= rd_ack_q1;
            rd_ack_d <= rd_ack_s;
        end
    end

    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            rd_hold_link <= 8'h00;
        end
        else if (rd_ack_s != rd_ack_d)
        begin
            rd_hold_link <= rd_hold;
        end
    end

    // bits taken on clock rise, driven after fall
    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            state <= PSS_IDLE;
            bit_cnt <= 3'h0;
            shift <= 8'h00;
            tx <= 8'h00;
            ptr <= `PSS_PTR_RESET;
            is_read <= 1'b0;
            is_alert <= 1'b0;
            ack_on <= 1'b0;
            sda_oe <= 1'b0;
            busy <= 1'b0;
            push_valid <= 1'b0;
            push_data <= '0;
            alert_tgl <= 1'b0;
            rd_req_tgl <= 1'b0;
        end
        else
        begin
            push_valid <= 1'b0;
            if (start_seen)
            begin
                // repeated start keeps the pointer
                state <= PSS_ADDR;
                bit_cnt <= 3'h0;
                ack_on <= 1'b0;
                sda_oe <= 1'b0;
                busy <= 1'b1;
            end
            else if (stop_seen)
            begin
                state <= PSS_IDLE;
                sda_oe <= 1'b0;
                busy <= 1'b0;
                ptr <= `PSS_PTR_RESET;
            end
            else
            begin
                case (state)
                    PSS_ADDR, PSS_CMD, PSS_WDATA:
                    begin
                        if (scl_rise)
                        begin
                            shift <= rx_byte;
                            bit_cnt <= bit_cnt + 3'h1;
                            if (bit_cnt == 3'h7)
                            begin
                                if (state == PSS_ADDR)
                                begin
                                    is_alert <= 1'b0;
                                    is_read <= rx_byte[`PSS_RW_BIT];
                                    if (primary_match(rx_byte[7:1], pins_s))
                                    begin
                                        state <= PSS_ADDR_ACK;
                                        if (rx_byte[`PSS_RW_BIT])
                                        begin
                                            rd_req_tgl <= !rd_req_tgl;
                                        end
                                    end
                                    else if (rx_byte[7:1] == `PSS_BROADCAST_ADDR
                                             && !rx_byte[`PSS_RW_BIT])
                                    begin
                                        state <= PSS_ADDR_ACK;
                                    end
                                    else if (rx_byte[7:1] == `PSS_ALERT_ADDR
                                             && rx_byte[`PSS_RW_BIT] && int_s)
                                    begin
                                        state <= PSS_ADDR_ACK;
                                        is_alert <= 1'b1;
                                        tx <= {`PSS_PRIMARY_TOP, pins_s, 1'b1};
                                    end
                                    else
                                    begin
                                        state <= PSS_IGNORE;
                                    end
                                end
                                else if (state == PSS_CMD)
                                begin
                                    ptr <= rx_byte[`PSS_PTR_WIDTH-1:0];
                                    state <= PSS_CMD_ACK;
                                end
                                else if (wq.push_ready)
                                begin
                                    push_valid <= 1'b1;
                                    push_data <= {ptr, rx_byte};
                                    state <= PSS_WDATA_ACK;
                                end
                                else
                                begin
                                    // full queue: refuse
                                    state <= PSS_IGNORE;
                                end
                            end
                        end
                    end
                    PSS_ADDR_ACK, PSS_CMD_ACK, PSS_WDATA_ACK:
                    begin
                        if (scl_fall)
                        begin
                            if (!ack_on)
                            begin
                                ack_on <= 1'b1;
                                sda_oe <= 1'b1;
                            end
                            else
                            begin
                                ack_on <= 1'b0;
                                bit_cnt <= 3'h0;
                                sda_oe <= 1'b0;
                                if (state == PSS_ADDR_ACK && is_read)
                                begin
                                    state <= PSS_RDATA;
                                    if (!is_alert)
                                    begin
                                        tx <= rd_hold_link;
                                        sda_oe <= !rd_hold_link[7];
                                    end
                                    else
                                    begin
                                        sda_oe <= !tx[7];
                                    end
                                end
                                else if (state == PSS_ADDR_ACK)
                                begin
                                    state <= PSS_CMD;
                                end
                                else if (state == PSS_CMD_ACK)
                                begin
                                    state <= PSS_WDATA;
                                end
                                else
                                begin
                                    state <= PSS_IGNORE;
                                end
                            end
                        end
                    end
                    PSS_RDATA:
                    begin
                        if (scl_rise)
                        begin
                            if (is_alert && tx[~bit_cnt] && !sda_s)
                            begin
                                state <= PSS_IGNORE;
                                sda_oe <= 1'b0;
                            end
                            else
                            begin
                                bit_cnt <= bit_cnt + 3'h1;
                                if (bit_cnt == 3'h7)
                                begin
                                    state <= PSS_RD_ACK;
                                    if (is_alert)
                                    begin
                                        alert_tgl <= !alert_tgl;
                                    end
                                end
                            end
                        end
                        else if (scl_fall)
                        begin
                            sda_oe <= !tx[~bit_cnt];
                        end
                    end
                    PSS_RD_ACK:
                    begin
                        if (scl_fall)
                        begin
                            sda_oe <= 1'b0;
                        end
                        if (scl_rise)
                        begin
                            state <= PSS_IGNORE;
                        end
                    end
                    PSS_IGNORE, PSS_IDLE:
                    begin
                        sda_oe <= 1'b0;
                    end
                    default:
                    begin
                        state <= PSS_IDLE;
                        sda_oe <= 1'b0;
                    end
                endcase
            end
        end
    end

    // open-drain: enable pulls low
    always_ff @(posedge link_clock or negedge lrst_n)
    begin
        if (!lrst_n)
        begin
            serial_data_output <= 1'b0;
            serial_data_output_oe <= 1'b0;
        end
        else
        begin
            serial_data_output <= 1'b0;
            serial_data_output_oe <= sda_oe;
        end
    end

    // system side crossings
    always_ff @(posedge clock or negedge srst_n)
    begin
        if (!srst_n)
        begin
            busy_q1 <= 1'b0;
            busy_s <= 1'b0;
            alert_q1 <= 1'b0;
            alert_s <= 1'b0;
            alert_d <= 1'b0;
            req_q1 <= 1'b0;
            req_s <= 1'b0;
            req_d <= 1'b0;
        end
        else
        begin
            busy_q1 <= busy;
            busy_s <= busy_q1;
            alert_q1 <= alert_tgl;
            alert_s <= alert_q1;
            alert_d <= alert_s;
            req_q1 <= rd_req_tgl;
            req_s <= req_q1;
            req_d <= req_s;
        end
    end

    // pointer stable until stop: safe to take
    always_ff @(posedge clock or negedge srst_n)
    begin
        if (!srst_n)
        begin
            rd_index <= `PSS_PTR_RESET;
            rd_strobe <= 1'b0;
            rd_hold <= 8'h00;
            rd_ack_tgl <= 1'b0;
        end
        else
        begin
            rd_strobe <= (req_s != req_d);
            if (req_s != req_d)
            begin
                rd_index <= ptr;
            end
            if (rd_strobe)
            begin
                rd_hold <= rd_data;
                rd_ack_tgl <= !rd_ack_tgl;
            end
        end
    end

    // re-armed once the cause is gone
    always_ff @(posedge clock or negedge srst_n)
    begin
        if (!srst_n)
        begin
            reset_pending <= 1'b1;
            armed <= 1'b1;
        end
        else if (alert_s != alert_d || int_release)
        begin
            reset_pending <= 1'b0;
            armed <= 1'b0;
        end
        else if (!event_pending && !reset_pending)
        begin
            armed <= 1'b1;
        end
    end

    // busy also covers a power-up start
    always_ff @(posedge clock or negedge srst_n)
    begin
        if (!srst_n)
        begin
            irq_n <= 1'b1;
        end
        else if (!busy_s)
        begin
            irq_n <= !((event_pending || reset_pending) && armed);
        end
    end

    always_ff @(posedge clock or negedge srst_n)
    begin
        if (!srst_n)
        begin
            wr_valid <= 1'b0;
            wr_index <= `PSS_PTR_RESET;
            wr_data <= 8'h00;
        end
        else if (!wr_valid || wr_ready)
        begin
            wr_valid <= wq.pop_valid;
            if (wq.pop_valid)
            begin
                wr_index <= wq.pop_data[QW-1:`PSS_DATA_WIDTH];
                wr_data <= wq.pop_data[`PSS_DATA_WIDTH-1:0];
            end
        end
    end
endmodule : pss_slave

`default_nettype wire

// [pss_note_end.sv]
`default_nettype none
`default_nettype wire

// [pss_slave_sva.sv]
`default_nettype none

module pss_slave_sva
    import pss_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic scl_in,
    input wire logic serial_data_input,
    input wire logic serial_data_output,
    input wire logic serial_data_output_oe,
    input wire logic irq_n,
    input wire logic rd_strobe,
    input wire logic wr_valid,
    input wire logic wr_ready,
    input wire pss_ptr_t wr_index,
    input wire pss_byte_t wr_data
);
    default clocking @(posedge clock); endclocking
    default disable iff (!nrst);
    logic ps, pd, busy;
    logic [6:0] bcnt, icnt;
    // raw bus view; 40-cycle margins cover sync delay
    always_ff @(posedge clock or negedge nrst)
    begin
        if (!nrst)
        begin
            ps <= 1'b1;
            pd <= 1'b1;
            busy <= 1'b0;
            bcnt <= 7'h0;
            icnt <= 7'h0;
        end
        else
        begin
            ps <= scl_in;
            pd <= serial_data_input;
            if (ps && scl_in && pd && !serial_data_input)
                busy <= 1'b1;
            else if (ps && scl_in && !pd && serial_data_input)
                busy <= 1'b0;
            bcnt <= busy ? bcnt + 7'(bcnt != 7'h7f) : 7'h0;
            icnt <= busy ? 7'h0 : icnt + 7'(icnt != 7'h7f);
        end
    end
    a_sdo_low: assert property (serial_data_output == 1'b0)
        else $error("data output not low");
    a_oe_rise_low: assert property ($rose(serial_data_output_oe) |-> !scl_in)
        else $error("drive began with clock high");
    a_oe_in_frame: assert property ($rose(serial_data_output_oe) |-> bcnt != 7'h0)
        else $error("drive outside a frame");
    a_oe_idle_free: assert property (icnt > 7'd40 |-> !serial_data_output_oe)
        else $error("data held after stop");
    a_irq_quiet_busy: assert property ($changed(irq_n) |-> bcnt < 7'd40)
        else $error("interrupt moved mid frame");
    a_irq_reset: assert property ($rose(nrst) |-> ##[1:30] !irq_n)
        else $error("no interrupt after reset");
    a_wr_hold: assert property (wr_valid && !wr_ready |=> wr_valid && $stable({wr_index, wr_data}))
        else $error("write word not held");
    a_rd_pulse: assert property (rd_strobe |=> !rd_strobe)
        else $error("read strobe too long");
endmodule : pss_slave_sva

`default_nettype wire

// [pss_host_model.sv]
`default_nettype none

module pss_host_model #(
    parameter int T = 300
) (
    output logic scl,
    output logic sda_m,
    input wire logic sda
);
    timeunit 1ns;
    timeprecision 100ps;
    initial
    begin
        scl = 1'b1;
        sda_m = 1'b1;
    end
    // data only moves while the clock is low
    task automatic clk_bit(input logic b, output logic s);
        sda_m = b;
        #T scl = 1'b1;
        #T s = sda;
        #T scl = 1'b0;
        #T;
    endtask : clk_bit
    task automatic start();
        sda_m = 1'b1;
        #T scl = 1'b1;
        #T sda_m = 1'b0;
        #T scl = 1'b0;
        #T;
    endtask : start
    task automatic stop();
        sda_m = 1'b0;
        #T scl = 1'b1;
        #T sda_m = 1'b1;
        #T;
    endtask : stop
    task automatic put(input logic [7:0] d, output logic ack);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(d[i], s);
        clk_bit(1'b1, s);
        ack = !s;
    endtask : put
    task automatic get(output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) clk_bit(1'b1, d[i]);
        clk_bit(1'b1, s);
    endtask : get
endmodule : pss_host_model

`default_nettype wire

// [tb.sv]
`default_nettype none

module tb
    import pss_pkg::*;
;
    timeunit 1ns;
    timeprecision 100ps;
    logic clock = 1'b0, link_clock = 1'b0, nrst = 1'b0, event_pending = 1'b0;
    logic int_release = 1'b0, wr_ready = 1'b0, stall = 1'b0;
    logic scl, sda_m, oe, sdo, irq_n, rd_strobe, wr_valid;
    logic [3:0] pins = 4'h0;
    pss_ptr_t rd_index, wr_index;
    pss_byte_t wr_data, rd_data;
    logic [15:0] q[$];
    int fails = 0, n_compared = 0, cyc = 0;
    wire sda = (oe ? sdo : 1'b1) & sda_m;
    assign rd_data = {3'h5, rd_index};
    always #5 clock = ~clock;
    initial
    begin
        #7;
        forever #40 link_clock = ~link_clock;
    end
    pss_slave u_dut (
        .clock(clock), .nrst(nrst), .link_clock(link_clock), .scl_in(scl),
        .serial_data_input(sda), .serial_data_output(sdo), .serial_data_output_oe(oe),
        .address_select_pins(pins), .irq_n(irq_n), .event_pending(event_pending),
        .int_release(int_release), .rd_index(rd_index), .rd_strobe(rd_strobe),
        .rd_data(rd_data), .wr_valid(wr_valid), .wr_index(wr_index), .wr_data(wr_data),
        .wr_ready(wr_ready)
    );
    pss_host_model u_host (.scl(scl), .sda_m(sda_m), .sda(sda));
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            fails++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : tally_and_finish
    task automatic wait_irq(input logic v);
        for (int i = 0; i < 200 && irq_n !== v; i++) @(posedge clock);
        #1;
    endtask : wait_irq
    task automatic drain();
        for (int i = 0; i < 300 && q.size() != 0; i++) @(posedge clock);
        #1;
        chk("queue_left", 16'(q.size()), 16'h0);
    endtask : drain
    task automatic wr(input logic [6:0] a, input logic [7:0] c, input logic [7:0] d,
                      output logic [2:0] k);
        k = 3'h0;
        u_host.start();
        u_host.put({a, 1'b0}, k[2]);
        if (k[2]) u_host.put(c, k[1]);
        if (k[1]) q.push_back({3'h0, c[4:0], d});
        if (k[1]) u_host.put(d, k[0]);
        if (k[1] && !k[0]) void'(q.pop_back());
        u_host.stop();
    endtask : wr
    task automatic rd(input logic [6:0] a, input logic [7:0] c, input logic rx,
                      output logic [7:0] d, output logic k);
        d = 8'h0;
        if (!rx)
        begin
            u_host.start();
            u_host.put({a, 1'b0}, k);
            u_host.put(c, k);
        end
        u_host.start();
        u_host.put({a, 1'b1}, k);
        if (k) u_host.get(d);
        u_host.stop();
    endtask : rd
    always @(posedge clock)
        wr_ready <= stall ? 1'b0 : 1'($urandom);
    always @(posedge clock)
        if (wr_valid === 1'b1 && wr_ready === 1'b1)
            chk("write_word", {3'h0, wr_index, wr_data}, q.size() ? q.pop_front() : 16'hffff);
    always @(posedge clock)
    begin
        cyc++;
        if (cyc == 90000)
        begin
            fails++;
            tally_and_finish();
        end
    end
    initial
    begin
        logic [2:0] k;
        logic [7:0] c, d;
        logic [6:0] adr;
        logic a;
        void'($urandom(32'hfe87));
        repeat (8) @(posedge clock);
        #1 nrst = 1'b1;
        wait_irq(1'b0);
        chk("irq_after_reset", irq_n, 1'b0);
        pins = 4'($urandom);
        rd(7'h0c, 8'h0, 1'b1, d, a);
        chk("alert_ack", a, 1'b1);
        chk("alert_addr", d, {3'b010, pins, 1'b1});
        wait_irq(1'b1);
        chk("irq_released", irq_n, 1'b1);
        rd(7'h0c, 8'h0, 1'b1, d, a);
        chk("alert_idle", a, 1'b0);
        event_pending = 1'b1;
        wait_irq(1'b0);
        chk("irq_event", irq_n, 1'b0);
        int_release = 1'b1;
        @(posedge clock);
        #1 int_release = 1'b0;
        wait_irq(1'b1);
        chk("irq_disarmed", irq_n, 1'b1);
        event_pending = 1'b0;
        $display("test interrupt done");
        for (int i = 0; i < 6; i++)
        begin
            pins = 4'($urandom);
            c = 8'($urandom);
            adr = (i % 3 == 0) ? {3'b010, pins} : (i % 3 == 1) ? 7'h30 : {3'b111, pins};
            wr(adr, c, 8'($urandom), k);
            chk("write_acks", k, (i % 3 == 2) ? 3'h0 : 3'h7);
        end
        drain();
        $display("test write done");
        c = 8'($urandom) | 8'he0;
        rd({3'b010, pins}, c, 1'b0, d, a);
        chk("read_byte", {a, d}, {1'b1, 3'h5, c[4:0]});
        rd({3'b010, pins}, 8'h0, 1'b1, d, a);
        chk("receive_byte", {a, d}, {1'b1, 8'ha0});
        rd(7'h30, 8'h0, 1'b1, d, a);
        chk("bcast_read", a, 1'b0);
        $display("test read done");
        stall = 1'b1;
        repeat (4) @(posedge clock);
        #1;
        for (int i = 0; i < 6; i++)
        begin
            wr({3'b010, pins}, 8'($urandom), 8'($urandom), k);
            chk("fill_ack", k[0], i < 5);
        end
        stall = 1'b0;
        drain();
        $display("test fill done");
        tally_and_finish();
    end
endmodule : tb

bind pss_slave pss_slave_sva u_sva (
    .clock(clock), .nrst(nrst), .scl_in(scl_in), .serial_data_input(serial_data_input),
    .serial_data_output(serial_data_output), .serial_data_output_oe(serial_data_output_oe),
    .irq_n(irq_n), .rd_strobe(rd_strobe), .wr_valid(wr_valid), .wr_ready(wr_ready),
    .wr_index(wr_index), .wr_data(wr_data)
);

`default_nettype wire
